// File: verilog/pdm_params.svh
// pdm_params.svh: constants for the dma master backend timing block
// assumes inclusion by the package, the design file and the bench
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH
`define PDM_CLK_PERIOD_NS 5
`define PDM_IRDY_LIMIT_CYC 8
`define PDM_RD_STB_LIMIT_CYC 7
`define PDM_RD_STB_OLD_CYC 6
`define PDM_WR_BE_LIMIT_CYC 8
`define PDM_CNT_W 4
`define PDM_CNT_ONE 4'h1
`define PDM_CNT_ZERO 4'h0
`define PDM_BAR_W 3
`define PDM_BAR_RST 3'h0
`define PDM_CMD_RD 4'h6
`define PDM_CMD_WR 4'h7
`endif

// File: verilog/pdm_pkg.sv
// pdm_pkg.sv: types for the dma master backend timing block
// assumes pdm_params.svh is on the include path
`include "pdm_params.svh"
package pdm_pkg;
  // master sequencer states, gray coded from idle through term
  typedef enum logic [2:0] {
    PDM_IDLE = 3'h0,
    PDM_START = 3'h1,
    PDM_ADDR = 3'h3,
    PDM_DATA = 3'h2,
    PDM_TERM = 3'h6
  } pdm_state_e;
  // backend control inputs grouped
  typedef struct packed {
    logic stop;
    logic wr_busy;
    logic rd_busy;
    logic stall;
  } pdm_ctl_s;
  typedef logic [`PDM_CNT_W-1:0] pdm_cnt_t;
endpackage

// File: verilog/pdm_master.sv
// pdm_master.sv: dma bus master timing and backend flow control
// assumes pci clock at 200 MHz, backend logic on the same clock
//
// What this block does
// - irdyn is asserted at most eight clocks after framen is asserted.
// - a grant withdrawn before framen is asserted abandons the cycle.
// - a halt request from the backend stops the transfer in progress.
// - write hold blocks write starts and read hold blocks read starts.
// - a stall input lets a slow backend delay framen safely.
// - framen is held off while address, command and parity are driven.
// - active output is valid and window select set during the transfer.
// - one extra burst write may follow one clock after active drops.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_params.svh"
module pdm_master
  import pdm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic [31:0] dma_addr,
  input wire logic [`PDM_BAR_W-1:0] dma_bar,
  input wire logic gnt_n,
  input wire logic trdy_n,
  input wire pdm_ctl_s ctl,
  input wire logic rd_data_ok,
  input wire logic write_enables_now,
  input wire logic last_word,
  output logic req_n,
  output logic frame_n,
  output logic frame_oe,
  output logic irdy_n,
  output logic irdy_oe,
  output logic [31:0] ad_out,
  output logic [3:0] cbe_n_out,
  output logic ad_oe,
  output logic par_out,
  output logic backend_cycle_start,
  output logic mast_active,
  output logic [`PDM_BAR_W-1:0] bar_select,
  output logic backend_wr,
  output logic dma_done
);

  //////////////////////////////////////////////////////////////////////////
  // state and next-state logic
  pdm_state_e state_q, state_d;
  pdm_cnt_t wait_q;
  logic wr_q, late_wr_q;
  logic start_ok, data_go, wait_max;

  // bus command for the transfer direction
  function automatic logic [3:0] cmd_of(input logic wr);
    return wr ? `PDM_CMD_WR : `PDM_CMD_RD;
  endfunction

  // busy holds gate the start per direction
  assign start_ok = dma_req && !gnt_n && !(dma_write ? ctl.wr_busy
                                                    : ctl.rd_busy);
  assign data_go = wr_q ? write_enables_now : rd_data_ok;
  assign wait_max = (wait_q == pdm_cnt_t'(`PDM_IRDY_LIMIT_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      PDM_IDLE: begin
        if (start_ok) state_d = PDM_START;
      end
      PDM_START: begin
        if (gnt_n) state_d = PDM_IDLE;
        else if (ctl.stop) state_d = PDM_IDLE;
        else if (!ctl.stall) state_d = PDM_ADDR;
      end
      PDM_ADDR: state_d = PDM_DATA;
      PDM_DATA: begin
        // halt or last word ends with a normal termination
        if (ctl.stop || (last_word && !irdy_n && !trdy_n))
          state_d = PDM_TERM;
      end
      PDM_TERM: begin
        if (!trdy_n || irdy_n) state_d = PDM_IDLE;
      end
      default: state_d = PDM_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_q <= PDM_IDLE;
    else state_q <= state_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // framen to irdyn counter, irdyn forced at the limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wait_q <= `PDM_CNT_ZERO;
    else if (state_q == PDM_ADDR) wait_q <= `PDM_CNT_ONE;
    else if (state_q == PDM_DATA && irdy_n && !wait_max)
      wait_q <= wait_q + `PDM_CNT_ONE;
    else if (state_q == PDM_IDLE) wait_q <= `PDM_CNT_ZERO;
  end

  // pci pin drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_n <= 1'b1;
      frame_n <= 1'b1;
      frame_oe <= 1'b0;
      irdy_n <= 1'b1;
      irdy_oe <= 1'b0;
    end else begin
      req_n <= !(dma_req || state_d != PDM_IDLE);
      frame_n <= !(state_d == PDM_ADDR || (state_d == PDM_DATA
                  && state_q != PDM_DATA) || (state_d == PDM_DATA
                  && !(last_word && data_go)));
      frame_oe <= (state_d != PDM_IDLE) && (state_d != PDM_START);
      // data ready or limit reached: irdy goes low
      irdy_n <= !((state_d == PDM_DATA && (data_go || wait_max))
                  || state_d == PDM_TERM);
      irdy_oe <= (state_d == PDM_DATA) || (state_d == PDM_TERM);
    end
  end

  // address, command and parity driven during startup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_out <= 32'h0;
      cbe_n_out <= 4'h0;
      ad_oe <= 1'b0;
      par_out <= 1'b0;
      wr_q <= 1'b0;
    end else if (state_q == PDM_IDLE && start_ok) begin
      ad_out <= dma_addr;
      cbe_n_out <= cmd_of(dma_write);
      par_out <= ^{dma_addr, cmd_of(dma_write)};
      ad_oe <= 1'b1;
      wr_q <= dma_write;
    end else if (state_d == PDM_IDLE) begin
      ad_oe <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // backend side signals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      backend_cycle_start <= 1'b0;
      mast_active <= 1'b0;
      bar_select <= `PDM_BAR_RST;
      backend_wr <= 1'b0;
      late_wr_q <= 1'b0;
      dma_done <= 1'b0;
    end else begin
      backend_cycle_start <= (state_q == PDM_IDLE) && start_ok;
      mast_active <= (state_d != PDM_IDLE);
      if (state_q == PDM_IDLE && start_ok) bar_select <= dma_bar;
      // one extra write may land after active drops
      late_wr_q <= wr_q && state_q == PDM_TERM && !trdy_n;
      backend_wr <= (wr_q && state_q == PDM_DATA && !irdy_n && !trdy_n)
                    || late_wr_q;
      dma_done <= (state_q != PDM_IDLE) && (state_d == PDM_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_irdy_limit: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(frame_n) |-> ##[0:8] !irdy_n)
    else $error("irdy not asserted within eight clocks of frame");
  a_grant_loss: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PDM_START && gnt_n) |=> state_q == PDM_IDLE)
    else $error("dma cycle not abandoned on grant loss");
  a_stop_halts: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PDM_DATA && ctl.stop) |=> state_q == PDM_TERM)
    else $error("halt request did not stop the transfer");
  a_halt_start: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PDM_START && ctl.stop && !gnt_n) |=> state_q == PDM_IDLE)
    else $error("halt request did not abandon the startup");
  a_wr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PDM_IDLE && ctl.wr_busy && dma_write)
      |=> state_q == PDM_IDLE)
    else $error("write started during write hold");
  a_rd_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PDM_IDLE && ctl.rd_busy && !dma_write)
      |=> state_q == PDM_IDLE)
    else $error("read started during read hold");
  a_stall_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PDM_START && ctl.stall && !gnt_n && !ctl.stop)
      |=> frame_n)
    else $error("frame asserted while stalled");
  a_addr_before: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(frame_n) |-> ad_oe && $past(ad_oe))
    else $error("address not driven before frame");
  a_cmd_parity: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(frame_n) |-> par_out == ^{ad_out, cbe_n_out})
    else $error("parity does not match address and command");
  a_active_xfer: assert property (@(posedge clk) disable iff (!rst_n)
    !irdy_n |-> mast_active)
    else $error("active low during a data phase");
  a_bar_stable: assert property (@(posedge clk) disable iff (!rst_n)
    mast_active && $past(mast_active) |-> $stable(bar_select))
    else $error("window select changed during the transfer");
  a_late_write: assert property (@(posedge clk) disable iff (!rst_n)
    backend_wr && !mast_active |-> $past(mast_active, 2))
    else $error("late write more than one clock after active");
  a_term_done: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PDM_TERM |-> ##[1:8] state_q == PDM_IDLE)
    else $error("termination did not complete");
  c_read_burst: cover property (@(posedge clk) disable iff (!rst_n)
    backend_cycle_start && !wr_q ##[1:20] dma_done);
  c_write_burst: cover property (@(posedge clk) disable iff (!rst_n)
    backend_wr ##1 backend_wr);
  c_grant_loss: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == PDM_START && gnt_n);
  c_late_write: cover property (@(posedge clk) disable iff (!rst_n)
    backend_wr && !mast_active);

endmodule // pdm_master
`default_nettype wire

// File: test/pdm_backend_model.sv
// pdm_backend_model.sv: backend and pci target stand-in for the bench
// assumes the master's clock and reset; one word per clock
`timescale 1ns/1ps
`default_nettype none
module pdm_backend_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] dly,
  input wire logic cyc_start,
  input wire logic active,
  input wire logic irdy_n,
  output logic data_ok,
  output logic trdy_n,
  output logic last_word
);
  logic [3:0] cnt_q;
  logic [3:0] words_q;
  // clocks since backend cycle start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 4'h0;
    else if (cyc_start) cnt_q <= 4'h1;
    else if (active && cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
  end
  // ready dly clocks after start, dly kept within limits
  assign data_ok = active && cnt_q != 4'h0 && cnt_q >= dly;
  // target answers at once; pulled up when idle
  assign trdy_n = !active || irdy_n;
  // words moved, fourth one is the last
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) words_q <= 4'h0;
    else if (cyc_start) words_q <= 4'h0;
    else if (!irdy_n && !trdy_n) words_q <= words_q + 4'h1;
  end
  assign last_word = active && words_q == 4'h3;
endmodule // pdm_backend_model
`default_nettype wire

// File: test/tb_top.sv
// tb_top.sv: self-checking bench for the dma master timing block
// assumes pdm_pkg and the backend model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pdm_params.svh"
module tb_top;
  import pdm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, dma_req = 1'b0, dma_write = 1'b0;
  logic gnt_n = 1'b0, trdy_n, last_word, data_ok, frame_n, frame_oe;
  logic irdy_n, irdy_oe, ad_oe, cyc_start, mast_active, backend_wr;
  logic dma_done, saw_frame, bar_ok, addr_first, term_ok;
  logic req_n, par_out, saw_req, addr_ok;
  logic [31:0] ad_out;
  logic [3:0] cbe_n_out, exp_cmd;
  logic [2:0] bar_select;
  logic [3:0] dly = 4'h1;
  pdm_ctl_s ctl = '0;
  int miscompares = 0, samples_checked = 0;
  int gap, gap_max, late_wr, starts;
  always #2.5 clk = ~clk;
  pdm_master pdm_master_i (.clk(clk), .rst_n(rst_n), .dma_req(dma_req),
    .dma_write(dma_write), .dma_addr(32'h00001040), .dma_bar(3'h5),
    .gnt_n(gnt_n), .trdy_n(trdy_n), .ctl(ctl),
    .rd_data_ok(data_ok & ~dma_write),
    .write_enables_now(data_ok & dma_write), .last_word(last_word),
    .req_n(req_n), .frame_n(frame_n), .frame_oe(frame_oe), .irdy_n(irdy_n),
    .irdy_oe(irdy_oe), .ad_out(ad_out), .cbe_n_out(cbe_n_out),
    .ad_oe(ad_oe), .par_out(par_out),
    .backend_cycle_start(cyc_start), .mast_active(mast_active),
    .bar_select(bar_select), .backend_wr(backend_wr), .dma_done(dma_done));
  pdm_backend_model pdm_backend_model_i (.clk(clk), .rst_n(rst_n),
    .dly(dly), .cyc_start(cyc_start), .active(mast_active),
    .irdy_n(irdy_n), .data_ok(data_ok), .trdy_n(trdy_n),
    .last_word(last_word));
  // watch bus pins each clock during a run
  always @(posedge clk) begin
    // address phase: first clock of frame low
    if (frame_oe && !frame_n && !saw_frame)
      addr_ok = ad_out === 32'h00001040 && cbe_n_out === exp_cmd
                && par_out === ^{32'h00001040, exp_cmd};
    if (!req_n) saw_req = 1'b1;
    if (frame_oe && !frame_n) saw_frame = 1'b1;
    gap = (frame_oe && !frame_n && irdy_n) ? gap + 1 : 0;
    if (gap > gap_max) gap_max = gap;
    if (mast_active && bar_select !== 3'h5) bar_ok = 1'b0;
    if (ad_oe && frame_n && !saw_frame) addr_first = 1'b1;
    if (irdy_oe && !irdy_n && frame_n) term_ok = 1'b1;
    if (backend_wr && !mast_active) late_wr = late_wr + 1;
    if (cyc_start) starts = starts + 1;
  end
  task automatic check(input string nm, input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // kind 1 stalls (cut drops grant), kind 2 holds busy, kind 0 cut halts
  task automatic run(input string nm, input logic wr, input logic [3:0] d,
                     input int hold, input int kind, input int cut);
    int n;
    n = 0;
    saw_frame = 0; bar_ok = 1; addr_first = 0; term_ok = 0;
    gap_max = 0; late_wr = 0; starts = 0;
    addr_ok = 1'b0;
    saw_req = 1'b0;
    exp_cmd = wr ? `PDM_CMD_WR : `PDM_CMD_RD;
    dly = d; dma_write = wr; dma_req = 1'b1;
    while (!dma_done && n < 100) begin
      ctl.stall = kind == 1 && n < hold;
      ctl.wr_busy = kind == 2 && n < hold && wr;
      ctl.rd_busy = kind == 2 && n < hold && !wr;
      if (kind == 2 && n == hold) check("start_held", starts == 0, 1'b1);
      if (kind == 1 && n == hold) check("frame_stall", saw_frame, 1'b0);
      if (n == cut && kind == 1) gnt_n = 1'b1;
      if (n == cut && kind == 0) ctl.stop = 1'b1;
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      final_report();
    end
    dma_req = 1'b0; gnt_n = 1'b0; ctl = '0;
    repeat (3) @(negedge clk);
    check("frame_seen", saw_frame,
          !(cut >= 0 && (kind == 1 || cut < 2)));
    check("req_seen", saw_req, 1'b1);
    if (saw_frame) begin
      check("irdy_gap", gap_max <= 8, 1'b1);
      check("addr_phase", addr_ok, 1'b1);
      check("addr_first", addr_first, 1'b1);
      check("term_phase", term_ok, 1'b1);
    end
    check("bar_held", bar_ok, 1'b1);
    check("late_writes", late_wr <= 1, 1'b1);
    $display("test %s done", nm);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    run("rd_fast", 1'b0, 4'h1, 0, 0, -1);
    run("rd_slow", 1'b0, 4'h6, 0, 0, -1);
    run("wr_slow", 1'b1, 4'h7, 0, 0, -1);
    run("rd_halt", 1'b0, 4'h1, 0, 0, 5);
    run("rd_stop_early", 1'b0, 4'h1, 0, 0, 0);
    run("wr_stall", 1'b1, 4'h2, 5, 1, -1);
    run("gnt_loss", 1'b0, 4'h1, 6, 1, 3);
    run("wr_hold", 1'b1, 4'h1, 6, 2, -1);
    run("rd_hold", 1'b0, 4'h1, 6, 2, -1);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
